// ===== hw/iotc_params.svh
// Register map, field positions, reset values and timing counts for the clock control block
`ifndef IOTC_PARAMS_SVH
`define IOTC_PARAMS_SVH

`define IOTC_ADDR_W          4
`define IOTC_OFF_TUNING      4'h0
`define IOTC_OFF_CONTROL     4'h4

`define IOTC_TUN_LFSRC_BIT   7
`define IOTC_TUN_MULTIPLIER_ENABLE_BIT   6
`define IOTC_TUN_TRIM_HI     4
`define IOTC_TUN_TRIM_LO     0

`define IOTC_CON_IDLE_BIT    7
`define IOTC_CON_IRCF_HI     6
`define IOTC_CON_IRCF_LO     4
`define IOTC_CON_STARTUP_TIMEOUT_FLAG_BIT    3
`define IOTC_CON_INTERNAL_FREQ_STABLE_FLAG_BIT    2
`define IOTC_CON_SCS_HI      1
`define IOTC_CON_SCS_LO      0

`define IOTC_IRCF_RESET      3'h4
`define IOTC_IRCF_8MHZ       3'h7
`define IOTC_IRCF_4MHZ       3'h6
`define IOTC_IRCF_31KHZ      3'h0
`define IOTC_IRCF_TOP        3'h7
`define IOTC_LF_DIV_MASK     8'hFF

`define IOTC_CFG_INTIO_A     4'h9
`define IOTC_CFG_INTIO_B     4'h8

`define IOTC_OLD_TICKS       2'h2
`define IOTC_NEW_TICKS       3'h3

`define IOTC_RESP_OKAY       2'h0
`define IOTC_RESP_SLVERR     2'h2

`endif

// ===== hw/iotc_pkg.sv
// Types shared by the clock control block
package iotc_pkg;

  typedef enum logic [1:0] {
    IOTC_SRC_PRI = 2'h0,
    IOTC_SRC_SEC = 2'h1,
    IOTC_SRC_INT = 2'h2
  } iotc_src_t;

  typedef enum logic [1:0] {
    IOTC_SW_IDLE = 2'h0,
    IOTC_SW_OLD  = 2'h1,
    IOTC_SW_NEW  = 2'h3
  } iotc_sw_t;

  // One-cycle rate enables from each oscillator
  typedef struct packed {
    logic primary_tick;
    logic secondary_tick;
    logic fast_osc_tick;
    logic slow_osc_tick;
  } iotc_ticks_t;

  // Levels reported by the oscillators and neighbouring units
  typedef struct packed {
    logic [3:0] primary_osc_config;
    logic       startup_timer_done;
    logic       fast_osc_stable;
    logic       secondary_osc_enable;
  } iotc_osc_status_t;

endpackage

// ===== hw/iotc_clock_control.sv
// Clock source select, internal oscillator tuning and status with an AXI4-Lite register port
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "iotc_params.svh"

// Notes on behaviour
// - Low-frequency select: fast oscillator divided by 256
// - Multiplier only at 4 or 8 MHz
// - Multiplier bit dead and zero outside the internal configurations
// - Trim field is a signed five-bit code
// - Clock select: 1x internal, 01 secondary, 00 primary
// - Clock select cleared on every reset
// - Source switch starts right after select write
// - Three-bit code picks internal output frequency
// - Frequency code change applies at once
// - Frequency code resets to 1 MHz
// - Watchdog always clocked from slow oscillator
// - Start-up flag set once timer expired, only while the primary source clocks the device
// - Internal stable flag when fast oscillator clocks
// - Secondary active flag while timer-1 oscillator clocks
// - At most one clock status flag set
// - Sleep instruction enters idle or full sleep
// - Secondary select ignored without oscillator enable
// - Glitch-free switch: two old, three new cycles
// - Multiplier allowed only in internal configurations
// - Trim settles without any completion indication
module iotc_clock_control (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [`IOTC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`IOTC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire iotc_pkg::iotc_ticks_t     osc_ticks,
  input  wire iotc_pkg::iotc_osc_status_t osc_status,
  input  wire logic                      sleep_exec,
  output iotc_pkg::iotc_src_t            active_source,
  output logic                           clock_hold,
  output logic                           device_clk_tick,
  output logic                           internal_clk_tick,
  output logic                           watchdog_clk_tick,
  output logic                           multiplier_on,
  output logic [4:0]                     freq_trim,
  output logic                           secondary_clock_active_flag,
  output logic                           sleep_enter,
  output logic                           idle_enter
);
  import iotc_pkg::*;

  logic              lf_src_ff;
  logic              multiplier_enable_ff;
  logic [4:0]        trim_ff;
  logic              idle_ff;
  logic [2:0]        ircf_ff;
  logic [1:0]        scs_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        psc_ff;
  logic              int_tick_ff;
  logic              dev_tick_ff;
  logic              wdt_tick_ff;
  logic              sleep_ff;
  logic              idle_ent_ff;
  iotc_sw_t          sw_ff;
  iotc_src_t         active_ff;
  iotc_src_t         target_ff;
  logic [1:0]        old_cnt_ff;
  logic [2:0]        new_cnt_ff;

  logic              wr_go;
  logic              rd_go;
  logic              pll_cfg_ok;
  logic [7:0]        tune_rd;
  logic [7:0]        ctrl_rd;
  logic [7:0]        div_mask;
  logic              int_tick;
  logic              uses_fast;
  iotc_src_t         req_src;
  iotc_src_t         want_src;
  logic              old_tick;
  logic              new_tick;
  logic              flag_ost;
  logic              flag_internal_freq_stable_flag;
  logic              flag_sec;
  logic              sw_start;

  // Bus slave: address and data are taken together, at most one write and one read response outstanding at a time
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go         = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  assign pll_cfg_ok = (osc_status.primary_osc_config == `IOTC_CFG_INTIO_A) ||
                      (osc_status.primary_osc_config == `IOTC_CFG_INTIO_B);

  always_comb begin
    tune_rd = 8'h00;
    tune_rd[`IOTC_TUN_LFSRC_BIT] = lf_src_ff;
    tune_rd[`IOTC_TUN_MULTIPLIER_ENABLE_BIT] = multiplier_enable_ff && pll_cfg_ok;
    tune_rd[`IOTC_TUN_TRIM_HI:`IOTC_TUN_TRIM_LO] = trim_ff;
    ctrl_rd = 8'h00;
    ctrl_rd[`IOTC_CON_IDLE_BIT] = idle_ff;
    ctrl_rd[`IOTC_CON_IRCF_HI:`IOTC_CON_IRCF_LO] = ircf_ff;
    ctrl_rd[`IOTC_CON_STARTUP_TIMEOUT_FLAG_BIT] = flag_ost;
    ctrl_rd[`IOTC_CON_INTERNAL_FREQ_STABLE_FLAG_BIT] = flag_internal_freq_stable_flag;
    ctrl_rd[`IOTC_CON_SCS_HI:`IOTC_CON_SCS_LO] = scs_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `IOTC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (s_axi_awaddr == `IOTC_OFF_TUNING || s_axi_awaddr == `IOTC_OFF_CONTROL) ?
                   `IOTC_RESP_OKAY : `IOTC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `IOTC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `IOTC_RESP_OKAY;
      if (s_axi_araddr == `IOTC_OFF_TUNING) begin
        rdata_ff <= {24'h000000, tune_rd};
      end else if (s_axi_araddr == `IOTC_OFF_CONTROL) begin
        rdata_ff <= {24'h000000, ctrl_rd};
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= `IOTC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Tuning register; bit 5 has no storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_src_ff <= 1'b0;
      multiplier_enable_ff  <= 1'b0;
      trim_ff   <= 5'h00;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `IOTC_OFF_TUNING) begin
      lf_src_ff <= s_axi_wdata[`IOTC_TUN_LFSRC_BIT];
      multiplier_enable_ff  <= s_axi_wdata[`IOTC_TUN_MULTIPLIER_ENABLE_BIT];
      trim_ff   <= s_axi_wdata[`IOTC_TUN_TRIM_HI:`IOTC_TUN_TRIM_LO];
    end
  end

  // Control register; status bits 3 and 2 are computed, never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ff <= 1'b0;
      ircf_ff <= `IOTC_IRCF_RESET;
      scs_ff  <= 2'h0;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `IOTC_OFF_CONTROL) begin
      idle_ff <= s_axi_wdata[`IOTC_CON_IDLE_BIT];
      ircf_ff <= s_axi_wdata[`IOTC_CON_IRCF_HI:`IOTC_CON_IRCF_LO];
      scs_ff  <= s_axi_wdata[`IOTC_CON_SCS_HI:`IOTC_CON_SCS_LO];
    end
  end

  // Trim goes straight to the oscillator as a two's complement code; it settles on its own
  assign freq_trim = trim_ff;

  assign multiplier_on = multiplier_enable_ff && pll_cfg_ok &&
                         (ircf_ff == `IOTC_IRCF_8MHZ || ircf_ff == `IOTC_IRCF_4MHZ);

  // Postscaler: divide by 2^(7-code), the 31 kHz slot by 256 from the fast oscillator
  assign div_mask = (ircf_ff == `IOTC_IRCF_31KHZ) ? `IOTC_LF_DIV_MASK :
                    8'((9'h001 << (`IOTC_IRCF_TOP - ircf_ff)) - 9'h001);

  always_comb begin
    if (ircf_ff == `IOTC_IRCF_31KHZ && !lf_src_ff) begin
      int_tick = osc_ticks.slow_osc_tick;
    end else begin
      int_tick = osc_ticks.fast_osc_tick && ((psc_ff & div_mask) == div_mask);
    end
  end

  assign uses_fast = (ircf_ff != `IOTC_IRCF_31KHZ) || lf_src_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_ff <= 8'h00;
    end else if (osc_ticks.fast_osc_tick) begin
      psc_ff <= psc_ff + 8'h01;
    end
  end

  // Source decode; a secondary request is held off while its oscillator is not enabled and switches once it is
  assign req_src  = scs_ff[1] ? IOTC_SRC_INT : (scs_ff[0] ? IOTC_SRC_SEC : IOTC_SRC_PRI);
  assign want_src = (req_src == IOTC_SRC_SEC && !osc_status.secondary_osc_enable) ? active_ff : req_src;

  function automatic logic src_tick(input iotc_src_t s, input iotc_ticks_t t, input logic it);
    unique case (s)
      IOTC_SRC_PRI: src_tick = t.primary_tick;
      IOTC_SRC_SEC: src_tick = t.secondary_tick;
      IOTC_SRC_INT: src_tick = it;
      default:      src_tick = 1'b0;
    endcase
  endfunction

  assign old_tick = src_tick(active_ff, osc_ticks, int_tick);
  assign new_tick = src_tick(target_ff, osc_ticks, int_tick);
  assign sw_start = (sw_ff == IOTC_SW_IDLE) && (want_src != active_ff);

  // Switch: hold the device clock for two old-source and three new-source cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_ff      <= IOTC_SW_IDLE;
      active_ff  <= IOTC_SRC_PRI;
      target_ff  <= IOTC_SRC_PRI;
      old_cnt_ff <= 2'h0;
      new_cnt_ff <= 3'h0;
    end else begin
      unique case (sw_ff)
        IOTC_SW_IDLE: begin
          if (sw_start) begin
            sw_ff      <= IOTC_SW_OLD;
            target_ff  <= want_src;
            old_cnt_ff <= 2'h0;
          end
        end
        IOTC_SW_OLD: begin
          if (old_tick) begin
            if (old_cnt_ff == `IOTC_OLD_TICKS - 2'h1) begin
              sw_ff      <= IOTC_SW_NEW;
              new_cnt_ff <= 3'h0;
            end else begin
              old_cnt_ff <= old_cnt_ff + 2'h1;
            end
          end
        end
        IOTC_SW_NEW: begin
          if (new_tick) begin
            if (new_cnt_ff == `IOTC_NEW_TICKS - 3'h1) begin
              sw_ff     <= IOTC_SW_IDLE;
              active_ff <= target_ff;
            end else begin
              new_cnt_ff <= new_cnt_ff + 3'h1;
            end
          end
        end
        default: sw_ff <= IOTC_SW_IDLE;
      endcase
    end
  end

  assign clock_hold    = (sw_ff != IOTC_SW_IDLE);
  assign active_source = active_ff;

  // Flags qualified by the settled source, so they stay mutually exclusive through a switch
  assign flag_ost  = !clock_hold && active_ff == IOTC_SRC_PRI && osc_status.startup_timer_done;
  assign flag_internal_freq_stable_flag = !clock_hold && active_ff == IOTC_SRC_INT && uses_fast &&
                     osc_status.fast_osc_stable;
  assign flag_sec  = !clock_hold && active_ff == IOTC_SRC_SEC;
  assign secondary_clock_active_flag = flag_sec;

  // Output strobes are registered, so each lags its source tick by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_tick_ff <= 1'b0;
      dev_tick_ff <= 1'b0;
      wdt_tick_ff <= 1'b0;
    end else begin
      int_tick_ff <= int_tick;
      dev_tick_ff <= old_tick && !clock_hold;
      wdt_tick_ff <= osc_ticks.slow_osc_tick;
    end
  end

  assign internal_clk_tick = int_tick_ff;
  assign device_clk_tick   = dev_tick_ff;
  assign watchdog_clk_tick = wdt_tick_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_ff    <= 1'b0;
      idle_ent_ff <= 1'b0;
    end else begin
      sleep_ff    <= sleep_exec && !idle_ff;
      idle_ent_ff <= sleep_exec && idle_ff;
    end
  end

  assign sleep_enter = sleep_ff;
  assign idle_enter  = idle_ent_ff;

  sel_reset_a: assert property (@(posedge aclk) !aresetn |=> scs_ff == 2'h0 && active_ff == IOTC_SRC_PRI)
    else $error("clock select not cleared by reset");

  ircf_reset_a: assert property (@(posedge aclk) !aresetn |=> ircf_ff == `IOTC_IRCF_RESET)
    else $error("frequency code not at 1 MHz after reset");

  pll_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      multiplier_on |-> pll_cfg_ok && ircf_ff[2] && ircf_ff[1])
    else $error("multiplier on outside 4 or 8 MHz internal mode");

  pll_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !pll_cfg_ok |-> !tune_rd[`IOTC_TUN_MULTIPLIER_ENABLE_BIT])
    else $error("multiplier bit reads one in wrong configuration");

  flags_onehot_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot0({flag_ost, flag_internal_freq_stable_flag, flag_sec}))
    else $error("more than one clock status flag set");

  switch_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (active_ff != $past(active_ff)) |-> $past(sw_ff) == IOTC_SW_NEW &&
      $past(new_cnt_ff) == `IOTC_NEW_TICKS - 3'h1 && $past(new_tick))
    else $error("source changed without full new-source pause");

  switch_old_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (sw_ff == IOTC_SW_OLD ##1 sw_ff == IOTC_SW_NEW) |-> $past(old_tick) && $past(old_cnt_ff) == 2'h1)
    else $error("old-source pause not two cycles");

  sec_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sw_start && !osc_status.secondary_osc_enable |=> target_ff != IOTC_SRC_SEC)
    else $error("secondary selected while its oscillator is off");

  sleep_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_exec |=> (idle_enter == $past(idle_ff)) && (sleep_enter == !$past(idle_ff)))
    else $error("sleep instruction entered wrong mode");

  ost_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !osc_status.startup_timer_done |-> !flag_ost)
    else $error("start-up flag set while timer counting");

  lf_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
      int_tick && ircf_ff == `IOTC_IRCF_31KHZ && lf_src_ff |-> psc_ff == `IOTC_LF_DIV_MASK)
    else $error("low-frequency tick not at divide-by-256");

endmodule

// ===== testbench/iotc_clock_control_tb_top.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ns
`include "iotc_params.svh"
module iotc_clock_control_tb_top;
  import iotc_pkg::*;
  logic                   aclk;
  logic                   aresetn;
  logic [3:0]             s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0]             s_axi_awprot, s_axi_arprot;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [1:0]             s_axi_bresp, s_axi_rresp, last_resp;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_exec;
  logic                   clock_hold, device_clk_tick, internal_clk_tick, watchdog_clk_tick, multiplier_on;
  logic                   secondary_clock_active_flag, sleep_enter, idle_enter;
  logic [4:0]             freq_trim;
  logic [7:0]             cyc;
  logic [31:0]            v;
  iotc_ticks_t            osc_ticks;
  iotc_osc_status_t       osc_status;
  iotc_src_t              active_source;
  int                     fail_count;
  int                     total_checks;

  iotc_clock_control iotc_clock_control_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_ticks, .osc_status, .sleep_exec,
    .active_source, .clock_hold, .device_clk_tick, .internal_clk_tick, .watchdog_clk_tick,
    .multiplier_on, .freq_trim, .secondary_clock_active_flag, .sleep_enter, .idle_enter
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Periods of 2, 4, 1 and 8 cycles all divide 256, so tick counts over 256 cycles are exact
  always @(posedge aclk) begin
    cyc <= cyc + 8'h01;
    osc_ticks <= {cyc[0], &cyc[1:0], 1'b1, &cyc[2:0]};
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Writes the control register and watches the pause; an ignored request must not pause at all
  task automatic sw(input logic [7:0] d, input iotc_src_t exp, input logic ign);
    int n;
    int m;
    logic was_held;
    n = 0;
    m = 0;
    was_held = 1'b0;
    wr(`IOTC_OFF_CONTROL, d);
    repeat (100) begin
      @(posedge aclk);
      if (clock_hold === 1'b1) n++;
      if (was_held && device_clk_tick === 1'b1) m++;
      was_held = clock_hold;
    end
    check("hold length", ign ? (n == 0) : (n >= 5), 1);
    check("paused clock", m, 0);
    check("source", active_source, exp);
  endtask

  task automatic t_reset;
    int n;
    n = 0;
    rd(`IOTC_OFF_TUNING, v);
    check("tuning reset", v, 32'h00000000);
    rd(`IOTC_OFF_CONTROL, v);
    check("control reset", v, 32'h00000048);
    check("trim reset", freq_trim, 5'h00);
    // Primary ticks every second cycle, so 16 samples hold exactly 8 device ticks
    repeat (16) begin
      @(posedge aclk);
      if (device_clk_tick === 1'b1) n++;
    end
    check("device ticks", n, 8);
    $display("test reset done");
  endtask

  task automatic t_tuning;
    wr(`IOTC_OFF_TUNING, 8'hFF);
    rd(`IOTC_OFF_TUNING, v);
    check("tuning ro bits", v, 32'h0000009F);
    check("trim max", freq_trim, 5'h1F);
    wr(`IOTC_OFF_TUNING, 8'h10);
    check("trim min", freq_trim, 5'h10);
    wr(`IOTC_OFF_TUNING, 8'h11);
    check("trim step up", freq_trim, 5'h11);
    wr(`IOTC_OFF_TUNING, 8'h10);
    check("trim step down", freq_trim, 5'h10);
    osc_status.startup_timer_done <= 1'b0;
    wr(`IOTC_OFF_CONTROL, 8'h48);
    rd(`IOTC_OFF_CONTROL, v);
    check("startup flag clear", v, 32'h00000040);
    osc_status.startup_timer_done <= 1'b1;
    $display("test tuning done");
  endtask

  task automatic t_mult;
    osc_status.primary_osc_config <= `IOTC_CFG_INTIO_A;
    wr(`IOTC_OFF_TUNING, 8'h40);
    check("mult at 1 MHz", multiplier_on, 1'b0);
    wr(`IOTC_OFF_CONTROL, 8'h60);
    check("mult at 4 MHz", multiplier_on, 1'b1);
    wr(`IOTC_OFF_CONTROL, 8'h50);
    check("mult at 2 MHz", multiplier_on, 1'b0);
    osc_status.primary_osc_config <= `IOTC_CFG_INTIO_B;
    wr(`IOTC_OFF_CONTROL, 8'h70);
    check("mult at 8 MHz", multiplier_on, 1'b1);
    rd(`IOTC_OFF_TUNING, v);
    check("mult bit reads", v, 32'h00000040);
    osc_status.primary_osc_config <= 4'h2;
    @(posedge aclk);
    @(posedge aclk);
    check("mult off config", multiplier_on, 1'b0);
    rd(`IOTC_OFF_TUNING, v);
    check("mult bit zero", v, 32'h00000000);
    wr(`IOTC_OFF_CONTROL, 8'h40);
    $display("test multiplier done");
  endtask

  task automatic t_switch;
    sw(8'h42, IOTC_SRC_INT, 1'b0);
    rd(`IOTC_OFF_CONTROL, v);
    check("int flags", {v[7:0], secondary_clock_active_flag}, 9'h08C);
    osc_status.secondary_osc_enable <= 1'b0;
    sw(8'h41, IOTC_SRC_INT, 1'b1);
    osc_status.secondary_osc_enable <= 1'b1;
    sw(8'h41, IOTC_SRC_SEC, 1'b0);
    rd(`IOTC_OFF_CONTROL, v);
    check("sec flags", {v[7:0], secondary_clock_active_flag}, 9'h083);
    sw(8'h40, IOTC_SRC_PRI, 1'b0);
    rd(`IOTC_OFF_CONTROL, v);
    check("pri flags", {v[7:0], secondary_clock_active_flag}, 9'h090);
    sw(8'h43, IOTC_SRC_INT, 1'b0);
    $display("test switch done");
  endtask

  // Code 8 stands for code 000 with the divided fast oscillator as low-frequency source
  task automatic t_freq;
    int n;
    for (int k = 0; k < 9; k++) begin
      wr(`IOTC_OFF_TUNING, (k == 8) ? 8'h80 : 8'h00);
      wr(`IOTC_OFF_CONTROL, {1'b0, k[2:0], 4'h2});
      n = 0;
      repeat (256) begin
        @(posedge aclk);
        if (internal_clk_tick === 1'b1) n++;
      end
      check("internal ticks", n, (k == 8) ? 1 : (k == 0) ? 32 : (256 >> (7 - k)));
      rd(`IOTC_OFF_CONTROL, v);
      check("stable flag", v[2], k != 0);
    end
    $display("test frequency done");
  endtask

  task automatic t_sleep;
    for (int i = 0; i < 2; i++) begin
      wr(`IOTC_OFF_CONTROL, i[0] ? 8'h42 : 8'hC2);
      sleep_exec <= 1'b1;
      @(posedge aclk);
      sleep_exec <= 1'b0;
      @(posedge aclk);
      check("sleep kind", {idle_enter, sleep_enter}, i[0] ? 2'b01 : 2'b10);
    end
    $display("test sleep done");
  endtask

  task automatic t_wdt;
    logic prev;
    wr(`IOTC_OFF_TUNING, 8'h80);
    @(posedge aclk);
    prev = osc_ticks.slow_osc_tick;
    repeat (32) begin
      @(posedge aclk);
      check("watchdog tick", watchdog_clk_tick, prev);
      prev = osc_ticks.slow_osc_tick;
    end
    $display("test watchdog done");
  endtask

  task automatic t_unmapped;
    rd(4'h8, v);
    check("unmapped read resp", last_resp, `IOTC_RESP_SLVERR);
    check("unmapped read data", v, 32'h00000000);
    wr(4'hC, 8'h00);
    check("unmapped write", last_resp, `IOTC_RESP_SLVERR);
    rd(`IOTC_OFF_TUNING, v);
    check("no side effect", v, 32'h00000080);
    $display("test unmapped done");
  endtask

  // Second reset while the internal block clocks the device
  task automatic t_mid_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("source after reset", active_source, IOTC_SRC_PRI);
    rd(`IOTC_OFF_CONTROL, v);
    check("control after reset", v, 32'h00000048);
    rd(`IOTC_OFF_TUNING, v);
    check("tuning after reset", v, 32'h00000000);
    $display("test mid reset done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The run needs well under 10000 cycles; this cuts a hung handshake short
  initial begin
    #500000;
    fail_count++;
    finish_test;
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    cyc = 8'h00;
    osc_ticks = '0;
    osc_status = {4'h2, 1'b1, 1'b1, 1'b1};
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_exec} = 6'h00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_tuning;
    t_mult;
    t_switch;
    t_freq;
    t_sleep;
    t_wdt;
    t_unmapped;
    t_mid_reset;
    finish_test;
  end
endmodule
